// ===== src/acs_pkg.sv
// constants and types of the converter conversion sequencer
//
// Contract
// - converter clock derived from cpu clock by selectable prescaler
// - prescaler runs while enabled, held in reset while disabled
// - set start bit, conversion begins on next converter clock rise
// - ordinary conversion lasts 13 converter clock cycles
// - first conversion after enable lasts 25 converter clock cycles
// - sample at 1.5 cycles, or 13.5 cycles for the first
// - at completion write result, set done flag, clear start if single
// - start may be set again; next conversion on following clock rise
// - auto trigger event resets the prescaler for fixed start delay
// - auto-triggered: sample two cycles after trigger, 13.5 cycles total
// - three cpu clock cycles of trigger synchronisation
// - free running: next conversion starts at completion, start stays set
// - channel and reference follow a buffer while idle
// - selection frozen at start, follows again in last cycle
// - free running: conversion already started keeps the old channel
// - input above reference yields codes near full scale
// - low-noise sleep with conditions met starts a conversion on halt
// - sleep-started conversion still raises completion request if woken
// - other sleep modes leave the enable state untouched
// - further trigger edges during a conversion are ignored
// - flag used as trigger must clear before it can trigger again
package acs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ACS_OFF_CTRL   = 4'h0;
  localparam logic [3:0] ACS_OFF_SEL    = 4'h4;
  localparam logic [3:0] ACS_OFF_RESULT = 4'h8;

  // converter_control_status_a fields
  localparam int ACS_BIT_ENABLE  = 0;
  localparam int ACS_BIT_START   = 1;
  localparam int ACS_BIT_AUTO    = 2;
  localparam int ACS_BIT_DONE    = 3;
  localparam int ACS_BIT_IRQEN   = 4;
  localparam int ACS_BIT_TRIGEXT = 5;
  localparam int ACS_BIT_DIV     = 8;

  // channel_reference_register fields
  localparam int ACS_BIT_CHAN = 0;
  localparam int ACS_BIT_REF  = 4;

  localparam logic [15:0] ACS_RST_CTRL = 16'h0000;
  localparam logic [15:0] ACS_RST_SEL  = 16'h0000;

  // ----------------------------------------
  // timing, in converter half cycles
  // ----------------------------------------
  localparam logic [5:0] ACS_SAMPLE_NORMAL = 6'h03; // 1.5 cycles
  localparam logic [5:0] ACS_DONE_NORMAL   = 6'h1a; // 13 cycles
  localparam logic [5:0] ACS_SAMPLE_FIRST  = 6'h1b; // 13.5 cycles
  localparam logic [5:0] ACS_DONE_FIRST    = 6'h32; // 25 cycles
  localparam logic [5:0] ACS_SAMPLE_AUTO   = 6'h04; // 2 cycles
  localparam logic [5:0] ACS_DONE_AUTO     = 6'h1b; // 13.5 cycles
  localparam logic [5:0] ACS_UNLOCK_BACK   = 6'h02; // last converter cycle

  localparam int ACS_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ACS_KIND_NORMAL,
    ACS_KIND_FIRST,
    ACS_KIND_AUTO
  } acs_kind_t;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_WAIT_EDGE,
    ACS_CONVERT
  } acs_phase_t;

endpackage

// ===== src/acs_prescaler.sv
// converter clock prescaler producing rise and fall ticks
`timescale 1ns/1ps
module acs_prescaler import acs_pkg::*; (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // control
  input  wire logic       enable,
  input  wire logic       clear,
  input  wire logic [2:0] divSel,
  // ticks, one cpu cycle each
  output logic            riseTick,
  output logic            fallTick
);

  typedef struct packed {
    logic [6:0] count;
  } acs_presc_t;

  acs_presc_t s_q;
  acs_presc_t s_d;

  // selects 0 and 1 both divide by two
  function automatic logic [7:0] ratioOf(input logic [2:0] sel);
    ratioOf = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
  endfunction

  logic [7:0] ratio;
  logic       wrap;

  always_comb begin
    ratio    = ratioOf(divSel);
    wrap     = ({1'b0, s_q.count} == ratio - 8'h01);
    riseTick = enable && !clear && wrap;
    fallTick = enable && !clear
               && ({1'b0, s_q.count} == (ratio >> 1) - 8'h01);
    s_d      = s_q;
    if (!enable || clear || wrap) begin
      s_d.count = 7'h00;
    end else begin
      s_d.count = s_q.count + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_presc_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    !enable |=> s_q.count == 7'h00)
    else $error("prescaler ran while off");

endmodule // acs_prescaler

// ===== src/acs_trig_sync.sv
// trigger synchroniser and rising edge detector
`timescale 1ns/1ps
module acs_trig_sync import acs_pkg::*; (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // asynchronous trigger
  input  wire logic trigIn,
  // one-cycle edge pulse
  output logic      trigEdge
);

  typedef struct packed {
    logic [ACS_SYNC_STAGES-1:0] ff;
    logic                       level;
    logic                       edgeHit;
  } acs_sync_t;

  acs_sync_t s_q;
  acs_sync_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.ff = {s_q.ff[1:0], trigIn};
    // only the second and third stages are looked at
    if (s_q.ff[1] == s_q.ff[2]) begin
      s_d.level = s_q.ff[2];
    end
    s_d.edgeHit = s_d.level && !s_q.level;
  end

  assign trigEdge = s_q.edgeHit;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // acs_trig_sync

// ===== src/acs_sequencer.sv
// converter conversion sequencer with register port
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module acs_sequencer import acs_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  // trigger and power state
  input  wire logic        trigIn,
  input  wire logic        cpuHalted,
  input  wire logic        sleepNoiseMode,
  // analog converter side
  input  wire logic [9:0]  resultIn,
  output logic             sampleHold,
  output logic             convActive,
  output logic      [3:0]  channelSel,
  output logic      [2:0]  referenceSel,
  output logic             doneIrqReq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic        enable;
    logic        start;
    logic        autoTrig;
    logic        doneFlag;
    logic        irqEn;
    logic        trigExt;
    logic [2:0]  divSel;
    logic [3:0]  chanBuf;
    logic [2:0]  refBuf;
    logic [3:0]  chanLive;
    logic [2:0]  refLive;
    acs_phase_t  phase;
    acs_kind_t   kind;
    logic        firstPend;
    logic [5:0]  half;
    logic [9:0]  result;
    logic [15:0] rdata;
    logic        sampleHold;
    logic        active;
    logic        irqReq;
    logic        haltPrev;
  } acs_state_t;

  acs_state_t s_q;
  acs_state_t s_d;

  function automatic logic [5:0] sampleAt(input acs_kind_t k);
    unique case (k)
      ACS_KIND_FIRST: sampleAt = ACS_SAMPLE_FIRST;
      ACS_KIND_AUTO:  sampleAt = ACS_SAMPLE_AUTO;
      default:        sampleAt = ACS_SAMPLE_NORMAL;
    endcase
  endfunction

  function automatic logic [5:0] doneAt(input acs_kind_t k);
    unique case (k)
      ACS_KIND_FIRST: doneAt = ACS_DONE_FIRST;
      ACS_KIND_AUTO:  doneAt = ACS_DONE_AUTO;
      default:        doneAt = ACS_DONE_NORMAL;
    endcase
  endfunction

  // ----------------------------------------
  // converter clock and trigger
  // ----------------------------------------
  logic riseTick;
  logic fallTick;
  logic trigEdge;
  logic autoStart;

  acs_prescaler uPresc (
    .mclk     (mclk),
    .rstn     (rstn),
    .enable   (s_q.enable),
    .clear    (autoStart),
    .divSel   (s_q.divSel),
    .riseTick (riseTick),
    .fallTick (fallTick)
  );

  acs_trig_sync uSync (
    .mclk     (mclk),
    .rstn     (rstn),
    .trigIn   (trigIn),
    .trigEdge (trigEdge)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       halfTick;
  logic [5:0] halfNext;
  logic       complete;
  logic       freeRun;
  logic       doneClr;
  logic       haltRise;
  logic       sleepStart;

  always_comb begin
    s_d        = s_q;
    s_d.rdata  = 16'h0000;
    s_d.sampleHold = 1'b0;
    doneClr    = 1'b0;
    halfTick   = riseTick || fallTick;
    halfNext   = s_q.half + 6'h01;
    freeRun    = s_q.autoTrig && !s_q.trigExt;
    // an edge during a conversion or a pending start is dropped
    autoStart  = s_q.enable && s_q.autoTrig && s_q.trigExt && trigEdge
                 && (s_q.phase == ACS_IDLE);
    complete   = (s_q.phase == ACS_CONVERT) && halfTick
                 && (halfNext == doneAt(s_q.kind));
    haltRise   = cpuHalted && !s_q.haltPrev;
    sleepStart = haltRise && sleepNoiseMode && s_q.enable && s_q.irqEn
                 && !s_q.autoTrig && !s_q.start
                 && (s_q.phase == ACS_IDLE);
    s_d.haltPrev = cpuHalted;

    // register reads, data in the following cycle only
    if (regRead) begin
      unique case (regAddr)
        ACS_OFF_CTRL: begin
          s_d.rdata[ACS_BIT_ENABLE]  = s_q.enable;
          s_d.rdata[ACS_BIT_START]   = s_q.start;
          s_d.rdata[ACS_BIT_AUTO]    = s_q.autoTrig;
          s_d.rdata[ACS_BIT_DONE]    = s_q.doneFlag;
          s_d.rdata[ACS_BIT_IRQEN]   = s_q.irqEn;
          s_d.rdata[ACS_BIT_TRIGEXT] = s_q.trigExt;
          s_d.rdata[ACS_BIT_DIV +: 3] = s_q.divSel;
        end
        ACS_OFF_SEL: begin
          s_d.rdata[ACS_BIT_CHAN +: 4] = s_q.chanBuf;
          s_d.rdata[ACS_BIT_REF +: 3]  = s_q.refBuf;
        end
        ACS_OFF_RESULT: begin
          s_d.rdata[9:0] = s_q.result;
        end
        default: begin
          s_d.rdata = 16'h0000;
        end
      endcase
    end

    // register writes; a write with enable set can set start but never clear it
    if (regWrite) begin
      unique case (regAddr)
        ACS_OFF_CTRL: begin
          s_d.enable   = regWdata[ACS_BIT_ENABLE];
          s_d.start    = s_q.start || regWdata[ACS_BIT_START];
          s_d.autoTrig = regWdata[ACS_BIT_AUTO];
          s_d.irqEn    = regWdata[ACS_BIT_IRQEN];
          s_d.trigExt  = regWdata[ACS_BIT_TRIGEXT];
          s_d.divSel   = regWdata[ACS_BIT_DIV +: 3];
          doneClr      = regWdata[ACS_BIT_DONE];
        end
        ACS_OFF_SEL: begin
          s_d.chanBuf = regWdata[ACS_BIT_CHAN +: 4];
          s_d.refBuf  = regWdata[ACS_BIT_REF +: 3];
        end
        default: begin
          s_d.enable = s_q.enable;
        end
      endcase
    end

    if (doneClr) begin
      s_d.doneFlag = 1'b0;
    end
    if (sleepStart) begin
      s_d.start = 1'b1;
    end

    // conversion sequence
    unique case (s_q.phase)
      ACS_IDLE: begin
        if (autoStart) begin
          s_d.phase = ACS_CONVERT;
          s_d.half  = 6'h00;
          s_d.start = 1'b1;
          s_d.kind  = s_q.firstPend ? ACS_KIND_FIRST : ACS_KIND_AUTO;
          s_d.firstPend = 1'b0;
        end else if (s_q.start && s_q.enable) begin
          s_d.phase = ACS_WAIT_EDGE;
        end
      end
      ACS_WAIT_EDGE: begin
        if (riseTick) begin
          s_d.phase = ACS_CONVERT;
          s_d.half  = 6'h00;
          s_d.kind  = s_q.firstPend ? ACS_KIND_FIRST : ACS_KIND_NORMAL;
          s_d.firstPend = 1'b0;
        end
      end
      ACS_CONVERT: begin
        if (halfTick) begin
          s_d.half = halfNext;
          if (halfNext == sampleAt(s_q.kind)) begin
            s_d.sampleHold = 1'b1;
          end
        end
        if (complete) begin
          // analog side saturates above the reference
          s_d.result   = resultIn;
          s_d.doneFlag = 1'b1;
          if (freeRun) begin
            s_d.phase = ACS_CONVERT;
            s_d.half  = 6'h00;
            s_d.kind  = ACS_KIND_NORMAL;
          end else begin
            s_d.phase = ACS_IDLE;
            s_d.start = 1'b0;
          end
        end
      end
    endcase

    // selection is locked during a conversion except in its last converter cycle
    if (s_q.phase != ACS_CONVERT
        || s_q.half >= doneAt(s_q.kind) - ACS_UNLOCK_BACK) begin
      s_d.chanLive = s_q.chanBuf;
      s_d.refLive  = s_q.refBuf;
    end

    // converter held idle while off; sleep never touches enable
    if (!s_d.enable) begin
      s_d.phase     = ACS_IDLE;
      s_d.start     = 1'b0;
      s_d.half      = 6'h00;
      s_d.firstPend = 1'b1;
      s_d.sampleHold = 1'b0;
    end
    s_d.active = (s_d.phase == ACS_CONVERT);
    s_d.irqReq = s_d.doneFlag && s_d.irqEn;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q           <= '0;
      s_q.phase     <= ACS_IDLE;
      s_q.kind      <= ACS_KIND_NORMAL;
      s_q.firstPend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata     = s_q.rdata;
  assign sampleHold   = s_q.sampleHold;
  assign convActive   = s_q.active;
  assign channelSel   = s_q.chanLive;
  assign referenceSel = s_q.refLive;
  assign doneIrqReq   = s_q.irqReq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_start_on_rise: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.phase == ACS_WAIT_EDGE && riseTick && s_d.enable
    |=> s_q.phase == ACS_CONVERT && s_q.half == 6'h00)
    else $error("start did not follow converter clock rise");

  a_normal_len: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.phase == ACS_CONVERT && s_q.kind == ACS_KIND_NORMAL
    |-> s_q.half < ACS_DONE_NORMAL)
    else $error("normal conversion overran 13 cycles");

  a_first_kind: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.phase == ACS_WAIT_EDGE && riseTick && s_q.firstPend && s_d.enable
    |=> s_q.kind == ACS_KIND_FIRST)
    else $error("first conversion not given 25 cycles");

  a_sample_point: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.sampleHold |-> s_q.half == sampleAt(s_q.kind))
    else $error("sample taken at wrong point");

  a_single_clear: assert property (
    @(posedge mclk) disable iff (!rstn)
    complete && !freeRun && s_d.enable
    |=> !s_q.start && s_q.doneFlag && s_q.result == $past(resultIn))
    else $error("single completion mishandled");

  a_free_rerun: assert property (
    @(posedge mclk) disable iff (!rstn)
    complete && freeRun && s_d.enable
    |=> s_q.phase == ACS_CONVERT && s_q.start && s_q.half == 6'h00)
    else $error("free running did not restart");

  a_select_lock: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.phase == ACS_CONVERT && $past(s_q.phase) == ACS_CONVERT
    && s_q.half < doneAt(s_q.kind) - ACS_UNLOCK_BACK
    && $past(s_q.half) <= s_q.half
    |=> s_q.chanLive == $past(s_q.chanLive))
    else $error("selection moved while locked");

  a_edge_ignored: assert property (
    @(posedge mclk) disable iff (!rstn)
    trigEdge && s_q.phase == ACS_CONVERT && !complete && s_d.enable
    |=> s_q.half >= $past(s_q.half))
    else $error("trigger restarted a running conversion");

  a_idle_follow: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.phase != ACS_CONVERT
    |=> s_q.chanLive == $past(s_q.chanBuf)
        && s_q.refLive == $past(s_q.refBuf))
    else $error("selection did not follow buffer while idle");

  a_sleep_start: assert property (
    @(posedge mclk) disable iff (!rstn)
    $rose(cpuHalted) && sleepNoiseMode && s_q.enable && s_q.irqEn
    && !s_q.autoTrig && s_q.phase == ACS_IDLE && s_d.enable
    |=> s_q.start)
    else $error("sleep entry did not start a conversion");

endmodule // acs_sequencer

// ===== bench/acs_analog_model.sv
// analog converter stand-in that captures the selection at the sample instant
`timescale 1ns/1ps
module acs_analog_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // from the sequencer
  input  wire logic       sampleHold,
  input  wire logic [3:0] channelSel,
  input  wire logic [2:0] referenceSel,
  // code back to the sequencer
  output logic      [9:0] resultIn
);
  // code encodes what was live when the input was held
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      resultIn <= 10'h000;
    end else if (sampleHold) begin
      resultIn <= {channelSel, referenceSel, 3'h5};
    end
  end
endmodule // acs_analog_model

// ===== bench/adc_conversion_sequencer_bench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  import acs_pkg::*;
  logic        mclk, rstn, regWrite, regRead, trigIn;
  logic        cpuHalted, sleepNoiseMode, sampleHold, convActive, doneIrqReq;
  logic [3:0]  regAddr, channelSel;
  logic [15:0] regWdata, regRdata, rv;
  logic [2:0]  referenceSel;
  logic [9:0]  resultIn;
  logic [3:0]  cm;
  int          n_mismatch, check_count, wn, ln, sm;

  acs_sequencer u_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .trigIn(trigIn), .cpuHalted(cpuHalted),
    .sleepNoiseMode(sleepNoiseMode), .resultIn(resultIn),
    .sampleHold(sampleHold), .convActive(convActive),
    .channelSel(channelSel), .referenceSel(referenceSel),
    .doneIrqReq(doneIrqReq));
  acs_analog_model u_ana (.mclk(mclk), .rstn(rstn), .sampleHold(sampleHold),
    .channelSel(channelSel), .referenceSel(referenceSel),
    .resultIn(resultIn));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // waits for a conversion, times it, rewrites the selection mid-way
  task automatic meas(input logic [15:0] midSel, output int w, output int l,
                      output int s, output logic [3:0] c);
    w = 0;
    l = 0;
    s = -1;
    // step off the edge so values launched there have settled
    #1;
    while (convActive !== 1'b1 && w < 300) begin
      @(posedge mclk);
      #1 w++;
    end
    if (w >= 300) begin
      n_mismatch++;
      results();
    end
    // free running never drops active, so completion is the request
    while (convActive === 1'b1 && doneIrqReq !== 1'b1 && l < 400) begin
      if (sampleHold === 1'b1) s = l;
      if (l == 5) begin
        regAddr  <= ACS_OFF_SEL;
        regWdata <= midSel;
        regWrite <= 1'b1;
      end
      if (l == 6) regWrite <= 1'b0;
      if (l == 10) c = channelSel;
      @(posedge mclk);
      #1 l++;
    end
    if (l >= 400) begin
      n_mismatch++;
      results();
    end
  endtask

  // counts cycles in which a conversion runs that should not
  task automatic quiet(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge mclk);
      #1 if (convActive !== 1'b0) h++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ACS_OFF_CTRL, rv);
    chk(rv, ACS_RST_CTRL);
    rd(ACS_OFF_SEL, rv);
    chk(rv, ACS_RST_SEL);
    rd(ACS_OFF_RESULT, rv);
    chk(rv, 16'h0000);
    rd(4'hc, rv);
    chk(rv, 16'h0000);
  endtask

  task automatic t_first();
    wr(ACS_OFF_SEL, 16'h0025);
    wr(ACS_OFF_CTRL, 16'h0011);
    wr(ACS_OFF_CTRL, 16'h0013);
    meas(16'h0025, wn, ln, sm, cm);
    chk(ln, 50);
    chk(sm, 27);
    #1 chk(doneIrqReq, 1'b1);
    rd(ACS_OFF_CTRL, rv);
    chk(rv, 16'h0019);
    rd(ACS_OFF_RESULT, rv);
    chk(rv, {6'h00, 4'h5, 3'h2, 3'h5});
  endtask

  task automatic t_lock();
    // start and done clear in one write, new selection late enough
    wr(ACS_OFF_CTRL, 16'h001b);
    meas(16'h0031, wn, ln, sm, cm);
    chk(ln, 26);
    chk(sm, 3);
    chk(cm, 4'h5);
    chk(channelSel, 4'h1);
    chk(referenceSel, 3'h3);
    rd(ACS_OFF_RESULT, rv);
    chk(rv, {6'h00, 4'h5, 3'h2, 3'h5});
  endtask

  task automatic t_div();
    wr(ACS_OFF_CTRL, 16'h021b);
    meas(16'h0031, wn, ln, sm, cm);
    chk(ln, 52);
    chk(wn <= 8, 1'b1);
  endtask

  task automatic t_free();
    wr(ACS_OFF_CTRL, 16'h001f);
    meas(16'h0031, wn, ln, sm, cm);
    chk(ln, 26);
    @(posedge mclk);
    #1 chk(convActive, 1'b1);
    rd(ACS_OFF_CTRL, rv);
    chk(rv[ACS_BIT_START], 1'b1);
    // new channel lands while the restarted conversion is locked
    wr(ACS_OFF_SEL, 16'h0022);
    wr(ACS_OFF_CTRL, 16'h001f);
    meas(16'h0022, wn, ln, sm, cm);
    rd(ACS_OFF_RESULT, rv);
    chk(rv, {6'h00, 4'h1, 3'h3, 3'h5});
    wr(ACS_OFF_CTRL, 16'h0019);
    meas(16'h0022, wn, ln, sm, cm);
    rd(ACS_OFF_RESULT, rv);
    chk(rv, {6'h00, 4'h2, 3'h2, 3'h5});
    quiet(300, wn);
    chk(wn, 0);
  endtask

  task automatic t_trig();
    wr(ACS_OFF_CTRL, 16'h003d);
    repeat (9) @(posedge mclk);
    trigIn <= 1'b1;
    fork
      meas(16'h0022, wn, ln, sm, cm);
      begin
        repeat (14) @(posedge mclk);
        trigIn <= 1'b0;
        repeat (2) @(posedge mclk);
        trigIn <= 1'b1;
      end
    join
    chk(wn >= ACS_SYNC_STAGES, 1'b1);
    chk(ln, 27);
    chk(sm, 4);
    quiet(300, wn);
    chk(wn, 0);
  endtask

  task automatic t_sleep();
    trigIn <= 1'b0;
    wr(ACS_OFF_CTRL, 16'h0019);
    sleepNoiseMode <= 1'b1;
    cpuHalted <= 1'b1;
    fork
      meas(16'h0022, wn, ln, sm, cm);
      begin
        // another wake source ends the halt mid-conversion
        repeat (12) @(posedge mclk);
        cpuHalted <= 1'b0;
      end
    join
    chk(ln, 26);
    #1 chk(doneIrqReq, 1'b1);
    // other sleep modes keep the converter enabled and idle
    wr(ACS_OFF_CTRL, 16'h0019);
    sleepNoiseMode <= 1'b0;
    cpuHalted <= 1'b1;
    quiet(300, wn);
    chk(wn, 0);
    rd(ACS_OFF_CTRL, rv);
    chk(rv[ACS_BIT_ENABLE], 1'b1);
    cpuHalted <= 1'b0;
  endtask

  task automatic t_reenable();
    wr(ACS_OFF_CTRL, 16'h0000);
    wr(ACS_OFF_CTRL, 16'h0013);
    meas(16'h0022, wn, ln, sm, cm);
    chk(ln, 50);
  endtask

  // ----------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    rstn = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    trigIn = 1'b0;
    cpuHalted = 1'b0;
    sleepNoiseMode = 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_first();
    t_lock();
    t_div();
    t_free();
    t_trig();
    t_sleep();
    t_reenable();
    results();
  end
endmodule // adc_conversion_sequencer_bench
